// file: hdl/lowd_defs.vh
`ifndef LOWD_DEFS_VH
`define LOWD_DEFS_VH
// ==================================================
// register map of the controller (AHB-Lite, word aligned)
`define LOWD_REG_CTRL     8'h00
`define LOWD_REG_ADDR     8'h04
`define LOWD_REG_WDATA    8'h08
`define LOWD_REG_STATUS   8'h0C
`define LOWD_REG_RDATA    8'h10
// ==================================================
// command register fields
`define LOWD_CMD_LSB      0
`define LOWD_CMD_MSB      2
`define LOWD_CTRL_GO      3
`define LOWD_CTRL_WMASK   4
`define LOWD_CTRL_DLY     5
// ==================================================
// command codes
`define LOWD_CMD_READ     3'h0
`define LOWD_CMD_WRITE    3'h1
`define LOWD_CMD_LOGSET   3'h2
`define LOWD_CMD_REFRESH  3'h3
`define LOWD_CMD_XFER     3'h4
// ==================================================
// status fields
`define LOWD_ST_BUSY      0
`define LOWD_ST_INIT      1
`define LOWD_ST_WIDTH1    2
// ==================================================
// function codes
`define LOWD_FC_WIDTH1    4'h3
`define LOWD_FC_PASS      4'h5
// ==================================================
// timing: ns figures and 5 ns clock derived counts
`define LOWD_CLK_NS       5
`define LOWD_PWRUP_NS     100000
`define LOWD_PWRUP_CYC    ((`LOWD_PWRUP_NS + `LOWD_CLK_NS - 1) / `LOWD_CLK_NS)
`define LOWD_INIT_RESETS  8
`define LOWD_TRP_NS       100
`define LOWD_TRP_CYC      ((`LOWD_TRP_NS + `LOWD_CLK_NS - 1) / `LOWD_CLK_NS)
`define LOWD_TRCD_NS      30
`define LOWD_TRCD_CYC     ((`LOWD_TRCD_NS + `LOWD_CLK_NS - 1) / `LOWD_CLK_NS)
`define LOWD_TCAS_NS      105
`define LOWD_TCAS_CYC     ((`LOWD_TCAS_NS + `LOWD_CLK_NS - 1) / `LOWD_CLK_NS)
`define LOWD_TCWD_NS      125
`define LOWD_TCWD_CYC     ((`LOWD_TCWD_NS + `LOWD_CLK_NS - 1) / `LOWD_CLK_NS)
`define LOWD_TFRS_NS      200
`define LOWD_TFRS_CYC     ((`LOWD_TFRS_NS + `LOWD_CLK_NS - 1) / `LOWD_CLK_NS)
`endif

// file: hdl/lowd_timer.v
`default_nettype none
// ==================================================
// down counter for strobe phase timing
module lowd_timer (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // load and status
   input  wire        i_load,
   input  wire [16:0] i_count,
   output wire        o_done
);
   reg [16:0] count;

   // load or count down to zero
   always @(posedge i_clk) begin
      if (i_rst) begin
         count <= 17'h00000;
      end else if (i_load) begin
         count <= i_count;
      end else if (count != 17'h00000) begin
         count <= count - 17'h00001;
      end
   end

   assign o_done = (count == 17'h00000) && !i_load;
endmodule
`default_nettype wire

// file: hdl/lowd_ahb_slave.v
`default_nettype none
`include "lowd_defs.vh"
// ==================================================
// AHB-Lite slave holding the controller registers
module lowd_ahb_slave (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // bus
   input  wire        i_hsel,
   input  wire [7:0]  i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [31:0] i_hwdata,
   output reg  [31:0] o_hrdata,
   // register contents
   output reg  [5:0]  o_ctrl,
   output reg  [15:0] o_addr,
   output reg  [3:0]  o_wdata,
   output reg         o_go,
   input  wire [2:0]  i_status,
   input  wire [3:0]  i_rdata
);
   reg        wr_pend;
   reg [7:0]  wr_addr;

   // address phase capture and write data phase
   always @(posedge i_clk) begin
      if (i_rst) begin
         wr_pend  <= 1'b0;
         wr_addr  <= 8'h00;
         o_ctrl   <= 6'h00;
         o_addr   <= 16'h0000;
         o_wdata  <= 4'h0;
         o_go     <= 1'b0;
         o_hrdata <= 32'h00000000;
      end else begin
         wr_pend <= i_hsel && i_htrans[1] && i_hwrite;
         wr_addr <= i_haddr;
         o_go    <= 1'b0;
         if (wr_pend) begin
            case (wr_addr)
               `LOWD_REG_CTRL: begin
                  o_ctrl <= i_hwdata[5:0];
                  o_go   <= i_hwdata[`LOWD_CTRL_GO];
               end
               `LOWD_REG_ADDR:  o_addr  <= i_hwdata[15:0];
               `LOWD_REG_WDATA: o_wdata <= i_hwdata[3:0];
               default: ;
            endcase
         end
         // read data ready in the data phase; unmapped reads zero
         if (i_hsel && i_htrans[1] && !i_hwrite) begin
            case (i_haddr)
               `LOWD_REG_CTRL:   o_hrdata <= {26'h0000000, o_ctrl};
               `LOWD_REG_ADDR:   o_hrdata <= {16'h0000, o_addr};
               `LOWD_REG_WDATA:  o_hrdata <= {28'h0000000, o_wdata};
               `LOWD_REG_STATUS: o_hrdata <= {29'h00000000, i_status};
               `LOWD_REG_RDATA:  o_hrdata <= {28'h0000000, i_rdata};
               default:          o_hrdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/lowd_ctrl.v
`default_nettype none
`include "lowd_defs.vh"
// ==================================================
// How it works
// - never sample data when timing ambiguous
// - data valid at column or write fall
// - wait 100 us, then 8 resets
// - clear mask, then one transfer cycle
// - set cycle needs column, write low
module lowd_ctrl (
   // clock and reset
   input  wire        I_CLK,
   input  wire        I_RST,
   // AHB-Lite slave
   input  wire        I_HSEL,
   input  wire [7:0]  I_HADDR,
   input  wire [1:0]  I_HTRANS,
   input  wire        I_HWRITE,
   input  wire [2:0]  I_HSIZE,
   input  wire [31:0] I_HWDATA,
   input  wire        I_HREADY,
   output wire [31:0] O_HRDATA,
   output reg         O_HREADYOUT,
   output reg         O_HRESP,
   // memory strobes and address
   output reg         O_RAS_N,
   output reg         O_CAS_N,
   output reg         O_WE_N,
   output reg         O_TRANSFER_SELECT_N,
   output reg  [7:0]  O_ADDR,
   // data pins, three signals each
   input  wire [3:0]  I_DQ,
   output reg  [3:0]  O_DQ,
   output reg  [3:0]  O_DQ_OE_N
);
   parameter PWRUP_CYC = `LOWD_PWRUP_CYC;

   // phase counts, cut to the timer width where loaded
   localparam integer TRCD_CYC = `LOWD_TRCD_CYC;
   localparam integer TCWD_CYC = `LOWD_TCWD_CYC;
   localparam integer TCAS_CYC = `LOWD_TCAS_CYC;
   localparam integer TFRS_CYC = `LOWD_TFRS_CYC;
   localparam integer TRP_CYC  = `LOWD_TRP_CYC;

   // state codes, one-hot
   localparam [7:0] S_PWR  = 8'h01;
   localparam [7:0] S_IDLE = 8'h02;
   localparam [7:0] S_ROW  = 8'h04;
   localparam [7:0] S_COL  = 8'h08;
   localparam [7:0] S_WEL  = 8'h10;
   localparam [7:0] S_HOLD = 8'h20;
   localparam [7:0] S_PRE  = 8'h40;
   localparam [7:0] S_LSET = 8'h80;

   // init sequence steps
   localparam [1:0] I_RESETS = 2'h0;
   localparam [1:0] I_MASK   = 2'h1;
   localparam [1:0] I_XFER   = 2'h2;
   localparam [1:0] I_DONE   = 2'h3;

   wire [5:0]  ctrl;
   wire [15:0] addr;
   wire [3:0]  wdata;
   wire        go;
   wire        t_done;
   reg         t_load;
   reg  [16:0] t_count;
   reg  [7:0]  state;
   reg  [1:0]  init_step;
   reg  [3:0]  init_cnt;
   reg  [2:0]  cmd;
   reg         use_mask;
   reg         delayed;
   reg         busy;
   reg         width1;
   reg  [3:0]  rdata;
   reg  [3:0]  cmd_data;

   // ==================================================
   // bus slave and phase timer
   lowd_ahb_slave u_slave (
      .i_clk    (I_CLK),
      .i_rst    (I_RST),
      .i_hsel   (I_HSEL && I_HREADY),
      .i_haddr  (I_HADDR),
      .i_htrans (I_HTRANS),
      .i_hwrite (I_HWRITE),
      .i_hwdata (I_HWDATA),
      .o_hrdata (O_HRDATA),
      .o_ctrl   (ctrl),
      .o_addr   (addr),
      .o_wdata  (wdata),
      .o_go     (go),
      .i_status ({width1, (init_step == I_DONE), busy}),
      .i_rdata  (rdata)
   );

   lowd_timer u_timer (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_load  (t_load),
      .i_count (t_count),
      .o_done  (t_done)
   );

   // ==================================================
   // command decode shared by launch paths
   function is_write;
      input [2:0] c;
      begin
         is_write = (c == `LOWD_CMD_WRITE);
      end
   endfunction

   // ==================================================
   // strobe sequencer
   always @(posedge I_CLK) begin
      if (I_RST) begin
         state               <= S_PWR;
         init_step           <= I_RESETS;
         init_cnt            <= 4'h0;
         cmd                 <= `LOWD_CMD_READ;
         use_mask            <= 1'b0;
         delayed             <= 1'b0;
         busy                <= 1'b1;
         width1              <= 1'b0;
         rdata               <= 4'h0;
         cmd_data            <= 4'h0;
         t_load              <= 1'b1;
         t_count             <= PWRUP_CYC[16:0];
         O_HREADYOUT         <= 1'b1;
         O_HRESP             <= 1'b0;
         O_RAS_N             <= 1'b1;
         O_CAS_N             <= 1'b1;
         O_WE_N              <= 1'b1;
         O_TRANSFER_SELECT_N <= 1'b1;
         O_ADDR              <= 8'h00;
         O_DQ                <= 4'h0;
         O_DQ_OE_N           <= 4'hF;
      end else begin
         t_load <= 1'b0;
         case (state)
            // power-up pause before anything
            S_PWR: begin
               if (t_done) begin
                  state <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (init_step == I_RESETS) begin
                  // logic reset cycle: pass code, refresh included
                  cmd      <= `LOWD_CMD_LOGSET;
                  O_ADDR   <= {4'h0, `LOWD_FC_PASS};
                  cmd_data <= 4'hF;
                  busy     <= 1'b1;
                  state    <= S_LSET;
               end else if (init_step == I_MASK) begin
                  // mask clear: all data lines high
                  cmd      <= `LOWD_CMD_LOGSET;
                  O_ADDR   <= {4'h0, `LOWD_FC_PASS};
                  cmd_data <= 4'hF;
                  busy     <= 1'b1;
                  state    <= S_LSET;
               end else if (init_step == I_XFER) begin
                  cmd      <= `LOWD_CMD_XFER;
                  O_ADDR   <= 8'h00;
                  busy     <= 1'b1;
                  state    <= S_ROW;
               end else if (go) begin
                  cmd      <= ctrl[`LOWD_CMD_MSB:`LOWD_CMD_LSB];
                  use_mask <= ctrl[`LOWD_CTRL_WMASK];
                  delayed  <= ctrl[`LOWD_CTRL_DLY];
                  cmd_data <= wdata;
                  busy     <= 1'b1;
                  if (ctrl[`LOWD_CMD_MSB:`LOWD_CMD_LSB] == `LOWD_CMD_LOGSET) begin
                     O_ADDR <= {4'h0, addr[3:0]};
                     if (addr[3:0] == `LOWD_FC_WIDTH1) begin
                        width1 <= 1'b1;
                     end
                     state <= S_LSET;
                  end else if (ctrl[`LOWD_CMD_MSB:`LOWD_CMD_LSB] == `LOWD_CMD_REFRESH) begin
                     state <= S_LSET;
                  end else begin
                     O_ADDR <= addr[15:8];
                     state  <= S_ROW;
                  end
               end else begin
                  busy <= 1'b0;
               end
            end
            // column low before row: refresh or set/reset
            S_LSET: begin
               O_CAS_N <= 1'b0;
               O_WE_N  <= (cmd == `LOWD_CMD_LOGSET) ? 1'b0 : 1'b1;
               if (cmd == `LOWD_CMD_LOGSET) begin
                  O_DQ      <= cmd_data;
                  O_DQ_OE_N <= 4'h0;
               end
               t_load  <= 1'b1;
               t_count <= TRCD_CYC[16:0];
               state   <= S_COL;
            end
            // row strobe falls; mask or mode sampled here
            S_ROW: begin
               O_RAS_N             <= 1'b0;
               O_TRANSFER_SELECT_N <= (cmd == `LOWD_CMD_XFER) ? 1'b0 : 1'b1;
               O_WE_N              <= !(is_write(cmd) && use_mask);
               if (is_write(cmd) && use_mask) begin
                  O_DQ      <= cmd_data;
                  O_DQ_OE_N <= 4'h0;
               end
               t_load  <= 1'b1;
               t_count <= TRCD_CYC[16:0];
               state   <= S_COL;
            end
            // column phase after row to column delay
            S_COL: begin
               if (t_done && O_RAS_N) begin
                  O_RAS_N <= 1'b0; // refresh style cycles
                  t_load  <= 1'b1;
                  t_count <= TFRS_CYC[16:0];
                  state   <= S_HOLD;
               end else if (t_done) begin
                  O_ADDR  <= addr[7:0];
                  O_CAS_N <= 1'b0;
                  O_WE_N  <= 1'b1;
                  O_DQ_OE_N <= 4'hF;
                  if (is_write(cmd) && !delayed) begin
                     O_WE_N    <= 1'b0;
                     O_DQ      <= cmd_data;
                     O_DQ_OE_N <= 4'h0;
                  end
                  t_load  <= 1'b1;
                  t_count <= (is_write(cmd) && delayed) ? TCWD_CYC[16:0] : TFRS_CYC[16:0];
                  state   <= (is_write(cmd) && delayed) ? S_WEL : S_HOLD;
               end
            end
            // delayed write: read data valid, then write strobe
            S_WEL: begin
               if (t_done) begin
                  rdata     <= I_DQ;
                  O_WE_N    <= 1'b0;
                  O_DQ      <= cmd_data;
                  O_DQ_OE_N <= 4'h0;
                  t_load    <= 1'b1;
                  t_count   <= TCAS_CYC[16:0];
                  state     <= S_HOLD;
               end
            end
            // strobes held low for the cycle
            S_HOLD: begin
               if (t_done) begin
                  if (cmd == `LOWD_CMD_READ) begin
                     rdata <= I_DQ;
                  end
                  O_RAS_N             <= 1'b1;
                  O_CAS_N             <= 1'b1;
                  O_WE_N              <= 1'b1;
                  O_TRANSFER_SELECT_N <= 1'b1;
                  O_DQ_OE_N           <= 4'hF;
                  t_load              <= 1'b1;
                  t_count             <= TRP_CYC[16:0];
                  state               <= S_PRE;
               end
            end
            // precharge, then advance init sequence
            S_PRE: begin
               if (t_done) begin
                  state <= S_IDLE;
                  case (init_step)
                     I_RESETS: begin
                        init_cnt <= init_cnt + 4'h1;
                        if (init_cnt == `LOWD_INIT_RESETS - 1) begin
                           init_step <= I_MASK;
                        end
                     end
                     I_MASK:  init_step <= I_XFER;
                     I_XFER:  init_step <= I_DONE;
                     default: init_step <= I_DONE;
                  endcase
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: testbench/lowd_ctrl_monitor.sv
`default_nettype none
// ==================================================
// strobe and bus checker on the controller ports
module lowd_ctrl_monitor #(
   parameter int PWRUP_CYC = 20
) (
   input wire logic       I_CLK,
   input wire logic       I_RST,
   input wire logic       O_HREADYOUT,
   input wire logic       O_HRESP,
   input wire logic       O_RAS_N,
   input wire logic       O_CAS_N,
   input wire logic       O_WE_N,
   input wire logic       O_TRANSFER_SELECT_N,
   input wire logic [3:0] O_DQ,
   input wire logic [3:0] O_DQ_OE_N
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [16:0] cyc;
   logic [3:0]  cbr;
   logic        mclr;
   logic        xdone;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   // ==================================================
   // init progress seen on the strobes
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         cyc   <= 17'h00000;
         cbr   <= 4'h0;
         mclr  <= 1'b0;
         xdone <= 1'b0;
      end else begin
         if (cyc != 17'h1FFFF) cyc <= cyc + 17'h00001;
         if ($fell(O_RAS_N) && !O_CAS_N && cbr != 4'hF) cbr <= cbr + 4'h1;
         if ($fell(O_RAS_N) && !O_CAS_N && !O_WE_N && O_DQ_OE_N == 4'h0 && O_DQ == 4'hF) mclr <= 1'b1;
         if ($fell(O_RAS_N) && O_CAS_N && !O_TRANSFER_SELECT_N) xdone <= 1'b1;
      end
   end
   // ==================================================
   // cycle steps
   sequence s_ras_cbr;
      $fell(O_RAS_N) && !O_CAS_N;
   endsequence
   sequence s_ras_norm;
      $fell(O_RAS_N) && O_CAS_N;
   endsequence
   sequence s_col_read;
      $fell(O_CAS_N) && !O_RAS_N && O_WE_N;
   endsequence
   sequence s_data_hold;
      O_DQ_OE_N == 4'h0 ##1 (O_DQ_OE_N == 4'h0 && $stable(O_DQ)) [*4];
   endsequence
   // ==================================================
   // assertions
   AST_BUS_OKAY: assert property (O_HREADYOUT && !O_HRESP)
      else $error("bus answer not ready or not okay");
   AST_PWRUP_QUIET: assert property (cyc + 1 < PWRUP_CYC |-> O_RAS_N)
      else $error("row strobe active during power-up pause");
   AST_INIT_RESETS: assert property (s_ras_norm |-> cbr >= 4'h9)
      else $error("access before init cycles done");
   AST_MASK_CLEARED: assert property (s_ras_norm |-> mclr)
      else $error("access before mask clear cycle");
   AST_XFER_FIRST: assert property (s_ras_norm ##0 O_TRANSFER_SELECT_N |-> xdone)
      else $error("access before first transfer cycle");
   AST_SET_MASK: assert property (s_ras_cbr ##0 !O_WE_N |-> O_DQ_OE_N == 4'h0)
      else $error("set cycle without mask data driven");
   AST_EARLY_DATA: assert property ($fell(O_CAS_N) && !O_RAS_N && !O_WE_N |-> s_data_hold)
      else $error("early write data not held at column fall");
   AST_LATE_DATA: assert property ($fell(O_WE_N) && !O_CAS_N && !O_RAS_N |-> s_data_hold)
      else $error("delayed write data not held at write fall");
   AST_READ_RELEASE: assert property (s_col_read |-> O_DQ_OE_N == 4'hF until (!O_WE_N || O_CAS_N))
      else $error("controller drives data during read");
   AST_READ_BOUND: assert property (s_col_read |-> ##[0:200] (!O_WE_N || O_CAS_N))
      else $error("read cycle column strobe stuck");
endmodule
bind lowd_ctrl lowd_ctrl_monitor #(.PWRUP_CYC(PWRUP_CYC)) i_lowd_ctrl_monitor (
   .I_CLK(I_CLK), .I_RST(I_RST), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
   .O_RAS_N(O_RAS_N), .O_CAS_N(O_CAS_N), .O_WE_N(O_WE_N),
   .O_TRANSFER_SELECT_N(O_TRANSFER_SELECT_N), .O_DQ(O_DQ), .O_DQ_OE_N(O_DQ_OE_N));
`default_nettype wire

// file: testbench/lowd_dram_model.sv
`default_nettype none
// ==================================================
// behavioural video memory random port
module lowd_dram_model #(
   parameter int ACC_NS = 50
) (
   input wire logic       clk,
   input wire logic       ras_n,
   input wire logic       cas_n,
   input wire logic       we_n,
   input wire logic       xfer_n,
   input wire logic [7:0] addr,
   input wire logic [3:0] ctl_dq,
   input wire logic [3:0] ctl_oe_n,
   output wire logic [3:0] dq
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0]  mem [0:65535];
   logic [7:0]  row;
   logic [7:0]  col;
   logic [15:0] serial_start;
   logic [3:0]  fc = 4'h5;
   logic [3:0]  mask2 = 4'hF;
   logic [3:0]  mask1;
   logic        m1, cbr, early;
   logic        width1 = 1'b0;
   logic        flt = 1'b0;
   int          ref_cnt = 0;
   wire         rd_on = !ras_n && !cas_n && we_n && !cbr && !early && xfer_n;
   wire         rd_dly;
   assign #(ACC_NS) rd_dly = rd_on;
   // released lines show a pattern that flips every cycle
   always @(posedge clk) flt <= ~flt;
   assign dq = (rd_on && rd_dly) ? mem[{row, col}] : (ctl_dq & ~ctl_oe_n) | ({4{flt}} & ctl_oe_n);
   // stored value per function code
   function automatic logic [3:0] lop(input logic [3:0] f, input logic [3:0] d, input logic [3:0] m);
      case (f)
         4'h0: lop = 4'h0;
         4'h1: lop = d & m;
         4'h2: lop = ~d & m;
         4'h4: lop = d & ~m;
         4'h6: lop = d ^ m;
         4'h7: lop = d | m;
         4'h8: lop = ~d & ~m;
         4'h9: lop = ~(d ^ m);
         4'hA: lop = ~d;
         4'hB: lop = ~d | m;
         4'hC: lop = ~m;
         4'hD: lop = d | ~m;
         4'hE: lop = ~d | ~m;
         4'hF: lop = 4'hF;
         default: lop = d;
      endcase
   endfunction
   // internal read-modify-write with masks
   task automatic store(input logic [3:0] d);
      logic [3:0] old;
      logic [3:0] e;
      old = mem[{row, col}];
      e = m1 ? mask1 : mask2;
      mem[{row, col}] = (lop(m1 ? 4'h5 : fc, d, old) & e) | (old & ~e);
   endtask
   // row strobe fall: refresh, set cycle or mask capture
   always @(negedge ras_n) begin
      #1;
      row = addr;
      cbr = !cas_n;
      early = 1'b0;
      m1 = 1'b0;
      if (cbr) begin
         ref_cnt++;
         if (!we_n) begin
            fc = addr[3:0];
            mask2 = dq;
            if (addr[3:0] == 4'h3) width1 = 1'b1;
         end
      end else if (!we_n) begin
         m1 = 1'b1;
         mask1 = dq;
      end
   end
   // column strobe fall: early write or transfer start
   always @(negedge cas_n) begin
      #1;
      if (!ras_n && !cbr) begin
         col = addr;
         if (!xfer_n) serial_start = {row, addr};
         else if (!we_n) begin
            early = 1'b1;
            store(dq);
         end
      end
   end
   // write strobe fall: delayed write
   always @(negedge we_n) begin
      #1;
      if (!ras_n && !cas_n && !cbr && !early && xfer_n) store(dq);
   end
endmodule
`default_nettype wire

// file: testbench/logic_op_write_dram_port_bench.sv
`default_nettype none
`include "lowd_defs.vh"
module logic_op_write_dram_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        I_CLK, I_RST, hsel, hwrite;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, v;
   logic        hready, hresp, ras_n, cas_n, we_n, xfer_n;
   logic [7:0]  maddr;
   logic [3:0]  dq_o, dq_oe_n, dq_bus;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          n0;
   // function code and expected result for old C, input A
   logic [7:0]  rows [15] = '{8'h00, 8'h18, 8'h24, 8'h42, 8'h5A, 8'h66, 8'h7E, 8'h81,
                              8'h99, 8'hA5, 8'hBD, 8'hC3, 8'hDB, 8'hE7, 8'hFF};
   lowd_ctrl #(.PWRUP_CYC(20)) i_lowd_ctrl (
      .I_CLK(I_CLK), .I_RST(I_RST), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
      .O_HREADYOUT(hready), .O_HRESP(hresp), .O_RAS_N(ras_n), .O_CAS_N(cas_n), .O_WE_N(we_n),
      .O_TRANSFER_SELECT_N(xfer_n), .O_ADDR(maddr), .I_DQ(dq_bus), .O_DQ(dq_o), .O_DQ_OE_N(dq_oe_n));
   lowd_dram_model #(.ACC_NS(50)) i_lowd_dram_model (
      .clk(I_CLK), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .xfer_n(xfer_n),
      .addr(maddr), .ctl_dq(dq_o), .ctl_oe_n(dq_oe_n), .dq(dq_bus));
   initial begin
      I_CLK = 1'b0;
      forever #2.5 I_CLK = ~I_CLK;
   end
   task end_sim;
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one single transfer, address then data phase
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge I_CLK);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge I_CLK); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge I_CLK); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // launch a command and wait until not busy
   task automatic cmd(input logic [2:0] c, input logic [15:0] a, input logic [3:0] d, input logic [1:0] fl);
      logic [31:0] r;
      bus(1'b1, `LOWD_REG_ADDR, {16'h0000, a}, r);
      bus(1'b1, `LOWD_REG_WDATA, {28'h0000000, d}, r);
      bus(1'b1, `LOWD_REG_CTRL, {26'h0000000, fl, 1'b1, c}, r);
      do bus(1'b0, `LOWD_REG_STATUS, 32'h00000000, r); while (r[`LOWD_ST_BUSY] !== 1'b0);
   endtask
   task automatic mem_rd(input logic [15:0] a, input logic [3:0] e, input string nm);
      logic [31:0] r;
      cmd(`LOWD_CMD_READ, a, 4'h0, 2'b00);
      bus(1'b0, `LOWD_REG_RDATA, 32'h00000000, r);
      chk(nm, e, r[3:0]);
   endtask
   task automatic setfc(input logic [3:0] f, input logic [3:0] m);
      cmd(`LOWD_CMD_LOGSET, {12'h000, f}, m, 2'b00);
   endtask
   always @(posedge I_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      {I_RST, hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b1, 12'h000, 3'h2, 32'h00000000};
      repeat (4) @(posedge I_CLK);
      I_RST <= 1'b0;
      bus(1'b0, `LOWD_REG_STATUS, 32'h00000000, v);
      chk("init flag early", 4'h0, {3'h0, v[`LOWD_ST_INIT]});
      do bus(1'b0, `LOWD_REG_STATUS, 32'h00000000, v); while (v[`LOWD_ST_INIT] !== 1'b1);
      chk("init refreshes", 4'h1, {3'h0, i_lowd_dram_model.ref_cnt >= 9});
      for (int i = 0; i < 15; i++) begin
         setfc(`LOWD_FC_PASS, 4'hF);
         cmd(`LOWD_CMD_WRITE, {12'h000, rows[i][7:4]}, 4'hC, 2'b00);
         setfc(rows[i][7:4], 4'hF);
         cmd(`LOWD_CMD_WRITE, {12'h000, rows[i][7:4]}, 4'hA, 2'b00);
         mem_rd({12'h000, rows[i][7:4]}, rows[i][3:0], "logic result");
      end
      // persistent mask from the set cycle
      setfc(`LOWD_FC_PASS, 4'hF);
      cmd(`LOWD_CMD_WRITE, 16'h0100, 4'h0, 2'b00);
      setfc(`LOWD_FC_PASS, 4'h3);
      cmd(`LOWD_CMD_WRITE, 16'h0100, 4'hF, 2'b00);
      mem_rd(16'h0100, 4'h3, "set mask write");
      cmd(`LOWD_CMD_WRITE, 16'h0100, 4'hC, 2'b00);
      mem_rd(16'h0100, 4'h0, "set mask kept");
      // per-cycle mask overrides function zero
      setfc(`LOWD_FC_PASS, 4'hF);
      cmd(`LOWD_CMD_WRITE, 16'h0200, 4'h9, 2'b00);
      setfc(4'h0, 4'hF);
      cmd(`LOWD_CMD_WRITE, 16'h0200, 4'h4, 2'b01);
      mem_rd(16'h0200, 4'hD, "cycle mask write");
      cmd(`LOWD_CMD_WRITE, 16'h0200, 4'hF, 2'b00);
      mem_rd(16'h0200, 4'h0, "function after mask");
      // delayed write returns old cell data
      setfc(`LOWD_FC_PASS, 4'hF);
      cmd(`LOWD_CMD_WRITE, 16'h0300, 4'hA, 2'b00);
      cmd(`LOWD_CMD_WRITE, 16'h0300, 4'h5, 2'b10);
      bus(1'b0, `LOWD_REG_RDATA, 32'h00000000, v);
      chk("delayed write read", 4'hA, v[3:0]);
      mem_rd(16'h0300, 4'h5, "delayed write data");
      // refresh in plain and set cycles
      n0 = i_lowd_dram_model.ref_cnt;
      cmd(`LOWD_CMD_REFRESH, 16'h0000, 4'h0, 2'b00);
      setfc(`LOWD_FC_PASS, 4'hF);
      chk("refresh count", 4'h2, 4'(i_lowd_dram_model.ref_cnt - n0));
      // one-bit serial width is sticky
      setfc(`LOWD_FC_WIDTH1, 4'hF);
      cmd(`LOWD_CMD_XFER, 16'h0000, 4'h0, 2'b00);
      setfc(`LOWD_FC_PASS, 4'hF);
      bus(1'b0, `LOWD_REG_STATUS, 32'h00000000, v);
      chk("width status", 4'h1, {3'h0, v[`LOWD_ST_WIDTH1]});
      chk("width device", 4'h1, {3'h0, i_lowd_dram_model.width1});
      // unmapped place leaves the controller idle
      bus(1'b1, 8'h20, 32'hFFFFFFFF, v);
      bus(1'b0, 8'h20, 32'h00000000, v);
      chk("unmapped read", 4'h0, v[3:0]);
      bus(1'b0, `LOWD_REG_STATUS, 32'h00000000, v);
      chk("busy after unmapped", 4'h0, {3'h0, v[`LOWD_ST_BUSY]});
      // second reset mid-run restarts the init sequence
      I_RST <= 1'b1;
      repeat (2) @(posedge I_CLK);
      I_RST <= 1'b0;
      bus(1'b0, `LOWD_REG_STATUS, 32'h00000000, v);
      chk("init after reset", 4'h0, {3'h0, v[`LOWD_ST_INIT]});
      do bus(1'b0, `LOWD_REG_STATUS, 32'h00000000, v); while (v[`LOWD_ST_INIT] !== 1'b1);
      chk("width after reset", 4'h0, {3'h0, v[`LOWD_ST_WIDTH1]});
      mem_rd(16'h0300, 4'h5, "data after reset");
      end_sim();
   end
endmodule
`default_nettype wire
